/* design/cce_crc_engine.sv */
`timescale 1ns/1ps
`include "cce_defines.svh"
module cce_crc_engine (
  input  wire logic       clk,
  input  wire logic       rst_n,
  cce_crc_if.engine       crc,
  input  wire logic [7:0] map_byte,
  input  wire logic       map_valid,
  input  wire logic       map_last
);
  import cce_pkg::*;

  cce_crc_state_t state_reg;
  cce_crc_state_t state_next;
  cce_crc_t       acc_reg;
  cce_crc_t       ref_reg;
  cce_crc_t       acc_upd;
  logic           mismatch_reg;

  function automatic cce_crc_t crc_byte(input cce_crc_t c,
                                        input logic [7:0] d);
    cce_crc_t r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CCE_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign acc_upd      = crc_byte(acc_reg, map_byte);
  assign crc.busy     = (state_reg != CCE_IDLE);
  assign crc.mismatch = mismatch_reg;

  // First pass to end after start is the reference, even if entered mid-pass; later passes compare
  always_comb begin
    state_next = state_reg;
    if (!crc.run || crc.restart) begin
      state_next = CCE_IDLE;
    end else begin
      unique case (state_reg)
        CCE_IDLE:    state_next = CCE_CAPTURE;
        CCE_CAPTURE: if (map_valid && map_last) state_next = CCE_CHECK;
        CCE_CHECK:   state_next = CCE_CHECK;
        default:     state_next = CCE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CCE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= `CCE_CRC_INIT;
    end else if (state_next == CCE_IDLE || state_reg == CCE_IDLE) begin
      acc_reg <= `CCE_CRC_INIT;
    end else if (map_valid) begin
      acc_reg <= map_last ? `CCE_CRC_INIT : acc_upd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_reg <= `CCE_CRC_RST;
    end else if (state_reg == CCE_CAPTURE && map_valid && map_last) begin
      ref_reg <= acc_upd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch_reg <= 1'b0;
    end else begin
      mismatch_reg <= state_reg == CCE_CHECK && state_next == CCE_CHECK &&
                      map_valid && map_last && acc_upd != ref_reg;
    end
  end
endmodule // cce_crc_engine

/* design/cce_crc_if.sv */
`timescale 1ns/1ps
interface cce_crc_if;
  logic run;
  logic restart;
  logic busy;
  logic mismatch;

  modport ctrl   (output run, output restart, input busy, input mismatch);
  modport engine (input run, input restart, output busy, output mismatch);
endinterface // cce_crc_if

/* design/cce_defines.svh */
`ifndef CCE_DEFINES_SVH
`define CCE_DEFINES_SVH

`define CCE_LOCK_KEY   8'ha5
`define CCE_NEG_AGND   4'h8
`define CCE_CRC_POLY   16'h8005
`define CCE_CRC_INIT   16'hffff
`define CCE_CRC_RST    16'h0000

`endif

/* design/cce_irq_ctrl.sv */
// Function
// - Checksum error holds interrupt low until cleared
// - Key 0xA5 write unlocks and clears error
// - Unlock halts checksum engine, drops interrupt
// - Start fast command restarts checksum, clears error
// - Continuous checksum, mismatch flags an error
// - Error outranks all interrupts except power-on
// - Error overrides modulator bitstream on pin
// - Negative select 1000 routes analogue ground
// - Status byte bit low once per error
// - Status register flag low until fully read
// - Upper mode bit passes only power-on, error, bitstream
`timescale 1ns/1ps
`include "cce_defines.svh"
module cce_irq_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] lock_key_byte,
  input  wire logic       lock_key_commit,
  input  wire logic       start_fast_cmd,
  input  wire logic [7:0] map_byte,
  input  wire logic       map_valid,
  input  wire logic       map_last,
  input  wire logic       por_irq,
  input  wire logic       other_irq,
  input  wire logic       irq_mode_hi,
  input  wire logic       modulator_bitstream_output_mode,
  input  wire logic       modulator_bitstream_output,
  input  wire logic       status_byte_sent,
  input  wire logic       irq_reg_read_done,
  input  wire logic [3:0] negative_input_select,
  output logic            irq_n,
  output logic            locked,
  output logic            config_checksum_error,
  output logic            sdo_cfg_flag_n,
  output logic            cfg_checksum_flag,
  output logic            neg_in_agnd
);
  import cce_pkg::*;

  cce_crc_if crc ();

  logic irq_n_reg;
  logic locked_reg;
  logic err_reg;
  logic err_next;
  logic sdo_flag_reg;
  logic reg_flag_reg;
  logic agnd_reg;
  logic key_unlock;
  logic key_lock;
  logic clear_err;
  logic irq_pin_next;

  // Key acts only on the committed byte, never on a partial shift
  assign key_unlock = lock_key_commit &&
                      lock_key_byte == `CCE_LOCK_KEY;
  assign key_lock   = lock_key_commit && lock_key_byte != `CCE_LOCK_KEY;
  assign clear_err  = key_unlock || start_fast_cmd;

  assign crc.run     = locked_reg;
  assign crc.restart = start_fast_cmd;

  cce_crc_engine u_crc (
    .clk       (clk),
    .rst_n     (rst_n),
    .crc       (crc),
    .map_byte  (map_byte),
    .map_valid (map_valid),
    .map_last  (map_last)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_reg <= 1'b0;
    end else if (key_unlock) begin
      locked_reg <= 1'b0;
    end else if (key_lock) begin
      locked_reg <= 1'b1;
    end
  end

  // A mismatch in the clearing cycle still sets: set wins over clear
  assign err_next = crc.mismatch || (err_reg && !clear_err);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= err_next;
    end
  end

  // Pin priority: power-on, checksum error, bitstream, other sources
  always_comb begin
    if (por_irq || err_next) begin
      irq_pin_next = 1'b0;
    end else if (modulator_bitstream_output_mode) begin
      irq_pin_next = modulator_bitstream_output;
    end else if (irq_mode_hi) begin
      irq_pin_next = 1'b1;
    end else begin
      irq_pin_next = !other_irq;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= irq_pin_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_flag_reg <= 1'b1;
    end else if (crc.mismatch) begin
      sdo_flag_reg <= 1'b0;
    end else if (status_byte_sent) begin
      sdo_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_flag_reg <= 1'b1;
    end else if (crc.mismatch) begin
      reg_flag_reg <= 1'b0;
    end else if (irq_reg_read_done) begin
      reg_flag_reg <= 1'b1;
    end
  end

  // Only the single-ended ground code is decoded here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      agnd_reg <= 1'b0;
    end else begin
      agnd_reg <= negative_input_select == `CCE_NEG_AGND;
    end
  end

  assign irq_n                 = irq_n_reg;
  assign locked                = locked_reg;
  assign config_checksum_error = err_reg;
  assign sdo_cfg_flag_n        = sdo_flag_reg;
  assign cfg_checksum_flag     = reg_flag_reg;
  assign neg_in_agnd           = agnd_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_err_pin_low: assert property (
    err_reg |-> !irq_n_reg)
    else $error("Pin high while checksum error pending");

  chk_unlock_clears: assert property (
    key_unlock && !crc.mismatch && !por_irq && !modulator_bitstream_output_mode && !other_irq
      |=> !err_reg && irq_n_reg)
    else $error("Key write did not clear error");

  chk_unlock_halts: assert property (
    key_unlock |=> ##1 !crc.busy)
    else $error("Checksum engine still busy after unlock");

  chk_start_clears: assert property (
    start_fast_cmd && !crc.mismatch |=> !err_reg)
    else $error("Start command did not clear error");

  chk_mismatch_sets: assert property (
    crc.mismatch |=> err_reg && !irq_n_reg)
    else $error("Mismatch did not raise error");

  chk_por_first: assert property (
    por_irq |=> !irq_n_reg)
    else $error("Power-on did not pull pin low");

  chk_modulator_bitstream_output_override: assert property (
    modulator_bitstream_output_mode && err_next && modulator_bitstream_output |=> !irq_n_reg)
    else $error("Bitstream not overridden by error");

  chk_agnd_route: assert property (
    negative_input_select == `CCE_NEG_AGND |=> neg_in_agnd)
    else $error("Ground code not routed");

  chk_status_byte: assert property (
    crc.mismatch |=> !sdo_cfg_flag_n)
    else $error("Status byte flag not low after error");

  chk_status_return: assert property (
    status_byte_sent && !crc.mismatch |=> sdo_cfg_flag_n)
    else $error("Status byte flag did not return high");

  chk_flag_returns: assert property (
    irq_reg_read_done && !crc.mismatch |=> cfg_checksum_flag)
    else $error("Register flag did not return high");

  chk_mode_mask: assert property (
    irq_mode_hi && !modulator_bitstream_output_mode && !por_irq && !err_next |=> irq_n_reg)
    else $error("Masked source reached the pin");

  chk_release_free: assert property (
    $fell(err_reg) && !$past(por_irq) && !$past(modulator_bitstream_output_mode) &&
      !$past(other_irq) |-> irq_n_reg)
    else $error("Pin stuck after clear");

  cov_error_raised: cover property (crc.mismatch ##1 err_reg);
  cov_unlock_clear: cover property (err_reg ##1 key_unlock ##1 !err_reg);
  cov_start_clear:  cover property (err_reg ##1 start_fast_cmd ##1 !err_reg);
  cov_modulator_bitstream_output_forced:  cover property (modulator_bitstream_output_mode && err_reg);
endmodule // cce_irq_ctrl

/* design/cce_pkg.sv */
package cce_pkg;

  typedef enum logic [1:0] {
    CCE_IDLE    = 2'b00,
    CCE_CAPTURE = 2'b01,
    CCE_CHECK   = 2'b11
  } cce_crc_state_t;

  typedef logic [15:0] cce_crc_t;

endpackage

/* tb/cce_host_model.sv */
`timescale 1ns/1ps
module cce_host_model (
  input  wire logic       clk,
  output logic      [7:0] lock_key_byte,
  output logic            lock_key_commit,
  output logic            start_fast_cmd,
  output logic            status_byte_sent,
  output logic            irq_reg_read_done
);
  initial begin
    lock_key_byte = 8'h00;
    lock_key_commit = 1'b0;
    start_fast_cmd = 1'b0;
    status_byte_sent = 1'b0;
    irq_reg_read_done = 1'b0;
  end
  // Key goes out whole in one commit pulse; stale bus after it
  task automatic send_key(input logic [7:0] k, input int gap);
    repeat (gap) @(negedge clk);
    lock_key_byte = k;
    lock_key_commit = 1'b1;
    @(negedge clk);
    lock_key_commit = 1'b0;
    lock_key_byte = ~k;
  endtask
  // Restart drops a spurious error and restarts the checksum
  task automatic send_start(input int gap);
    repeat (gap) @(negedge clk);
    start_fast_cmd = 1'b1;
    @(negedge clk);
    start_fast_cmd = 1'b0;
  endtask
  task automatic read_status(input logic sdo, input logic regrd);
    status_byte_sent = sdo;
    irq_reg_read_done = regrd;
    @(negedge clk);
    status_byte_sent = 1'b0;
    irq_reg_read_done = 1'b0;
  endtask
endmodule // cce_host_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic       clk, rst_n, kc, sc, ss, rd, mv, ml, ep;
  logic       por, oth, hi, md, mbit, irq_n, lk, err, sf, rf, agnd;
  logic [7:0] kb, mb;
  logic [3:0] sel;
  logic [7:0] data [4];
  int         error_cnt, n_compared, seed;

  always #5 clk = ~clk;

  cce_host_model host (.clk(clk), .lock_key_byte(kb), .lock_key_commit(kc),
    .start_fast_cmd(sc), .status_byte_sent(ss), .irq_reg_read_done(rd));
  cce_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .lock_key_byte(kb),
    .lock_key_commit(kc), .start_fast_cmd(sc), .map_byte(mb),
    .map_valid(mv), .map_last(ml), .por_irq(por), .other_irq(oth),
    .irq_mode_hi(hi), .modulator_bitstream_output_mode(md), .modulator_bitstream_output(mbit),
    .status_byte_sent(ss), .irq_reg_read_done(rd),
    .negative_input_select(sel), .irq_n(irq_n), .locked(lk),
    .config_checksum_error(err), .sdo_cfg_flag_n(sf),
    .cfg_checksum_flag(rf), .neg_in_agnd(agnd));

  function automatic logic exp_pin(logic e, logic p, logic o, logic h,
                                   logic m, logic b);
    if (p || e) return 1'b0;
    if (m) return b;
    if (h) return 1'b1;
    return !o;
  endfunction

  task automatic report_and_stop;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic send_pass(input logic [7:0] flip);
    for (int i = 0; i < 4; i++) begin
      mv = 1'b1;
      mb = data[i] ^ ((i == 2) ? flip : 8'h00);
      ml = (i == 3);
      @(negedge clk);
    end
    mv = 1'b0;
    ml = 1'b0;
    mb = ~mb;
  endtask

  task automatic wait_err;
    int n;
    n = 0;
    while (err !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    if (err !== 1'b1) begin
      error_cnt++;
      report_and_stop;
    end
  endtask

  initial begin
    {clk, rst_n, mv, ml, por, oth, hi, md, mbit} = 9'h000;
    mb = 8'h00;
    sel = 4'h0;
    error_cnt = 0;
    n_compared = 0;
    seed = $urandom(32'hb266d206);
    repeat (3) @(negedge clk);
    ep = {irq_n, lk, err, sf, rf, agnd} === 6'b100110;
    chk(ep, 1'b1, "reset");
    rst_n = 1'b1;
    for (int r = 0; r < 2; r++) begin
      foreach (data[i]) data[i] = 8'($urandom);
      host.send_key(8'h5a, $urandom_range(2));
      repeat (3) @(negedge clk);
      // Stale key bus now shows the unlock value without a commit
      chk(lk, 1'b1, "lock");
      send_pass(8'h00);
      @(negedge clk);
      send_pass(8'h00);
      repeat (4) @(negedge clk);
      chk(err, 1'b0, "clean pass");
      md = 1'b1;
      send_pass(8'h01 << $urandom_range(7));
      chk(err, 1'b0, "early error");
      wait_err;
      chk(irq_n, 1'b0, "err pin");
      chk(sf, 1'b0, "sdo flag");
      chk(rf, 1'b0, "reg flag");
      for (int i = 0; i < 8; i++) begin
        {oth, hi, md, mbit} = 4'($urandom) | 4'h2;
        @(negedge clk);
        chk(irq_n, 1'b0, "err held");
      end
      // Quiet pin sources on the unlock round so the release shows
      oth = 1'b0;
      md = (r == 1);
      host.read_status(1'b1, 1'b0);
      @(negedge clk);
      chk(sf, 1'b1, "sdo flag back");
      chk(rf, 1'b0, "reg flag held");
      host.read_status(1'b0, 1'b1);
      @(negedge clk);
      chk(rf, 1'b1, "reg flag back");
      chk(err, 1'b1, "err kept");
      // Unlock first, so the second round locks onto a fresh reference
      if (r == 0)
        host.send_key(8'ha5, 0);
      else
        host.send_start(1);
      @(negedge clk);
      chk(err, 1'b0, "clear");
      ep = exp_pin(1'b0, por, oth, hi, md, mbit);
      chk(irq_n, ep, "release");
      chk(lk, r == 1, "lock state");
      // Ignored while unlocked; after restart it is a fresh reference
      send_pass(8'hff);
      repeat (4) @(negedge clk);
      chk(err, 1'b0, "no error after clear");
    end
    for (int i = 0; i < 200; i++) begin
      {por, oth, hi, md, mbit} = 5'($urandom);
      sel = (i % 4 == 0) ? 4'h8 : 4'($urandom);
      @(negedge clk);
      ep = exp_pin(1'b0, por, oth, hi, md, mbit);
      chk(irq_n, ep, "pin");
      chk(agnd, sel == 4'h8, "agnd");
    end
    report_and_stop;
  end
endmodule // testbench
